// ---- logic/tat_pkg.sv ----
// constants, register layout and state types of the thermostat and result block
// assumes a 125 MHz core clock and a separate serial-link clock
package tat_pkg;

    localparam int          CLK_KHZ        = 125000;
    localparam int          CONV_TIME_9_MS = 150;
    localparam int          CONV_CYC_9     = CONV_TIME_9_MS * CLK_KHZ;

    localparam logic [1:0]  PTR_TEMP       = 2'h0;
    localparam logic [1:0]  PTR_CFG        = 2'h1;
    localparam logic [1:0]  PTR_LOWER      = 2'h2;
    localparam logic [1:0]  PTR_UPPER      = 2'h3;

    localparam int          CFG_STANDBY    = 0;
    localparam int          CFG_MODE       = 1;
    localparam int          CFG_POL        = 2;
    localparam int          CFG_FQ_LO      = 3;
    localparam int          CFG_FQ_HI      = 4;
    localparam int          CFG_RES_LO     = 5;
    localparam int          CFG_RES_HI     = 6;
    localparam logic [7:0]  CFG_RESET      = 8'h00;
    localparam logic [7:0]  CFG_WR_MASK    = 8'h7F;

    localparam logic [15:0] LOWER_RESET    = 16'h4800;
    localparam logic [15:0] UPPER_RESET    = 16'h5000;
    localparam logic [15:0] LIMIT_WR_MASK  = 16'hFFF0;
    localparam logic [15:0] TEMP_RESET     = 16'h0000;

    localparam logic [1:0]  RES_9          = 2'h0;
    localparam logic [1:0]  RES_10         = 2'h1;
    localparam logic [1:0]  RES_11         = 2'h2;
    localparam logic [15:0] MASK_9         = 16'hFF80;
    localparam logic [15:0] MASK_10        = 16'hFFC0;
    localparam logic [15:0] MASK_11        = 16'hFFE0;
    localparam logic [15:0] MASK_12        = 16'hFFF0;

    localparam logic [1:0]  FQ_1           = 2'h0;
    localparam logic [1:0]  FQ_2           = 2'h1;
    localparam logic [1:0]  FQ_4           = 2'h2;
    localparam logic [2:0]  FQ_CNT_1       = 3'h1;
    localparam logic [2:0]  FQ_CNT_2       = 3'h2;
    localparam logic [2:0]  FQ_CNT_4       = 3'h4;
    localparam logic [2:0]  FQ_CNT_6       = 3'h6;

    localparam int          SAMPLE_W       = 12;
    localparam logic [3:0]  LOW_ZERO       = 4'h0;
    localparam int          SYNC_W         = 3;

    typedef enum logic {
        TAT_CONVERT,
        TAT_STANDBY
    } tat_conv_e;

endpackage

// ---- logic/tat_thermostat.sv ----
// thermostat, result register and alarm pin of the temperature sensor
// assumes the serial engine presents register accesses on i_link_clk and
// that the analog front end presents a 12-bit sample on the core clock
//
// Operation
// RULE_01: each conversion result is kept as 16-bit two's complement, bit 15 sign.
// RULE_02: temperature reads return last finished result, never disturbing conversion.
// RULE_03: lowest four bits of the temperature word always read zero.
// RULE_04: result is left-justified by resolution; unused low bits read zero.
// RULE_05: each new result is compared with both limits, then alarm updated.
// RULE_06: limits are compared using only as many top bits as resolution.
// RULE_07: polarity bit inverts alarm active level; reset gives active low.
// RULE_08: after reset the block converts continuously and drives alarm standalone.
// RULE_09: comparator mode trips after queue-count consecutive results above upper limit.
// RULE_10: comparator mode alarm releases at first result below lower limit.
// RULE_11: in comparator mode entering standby leaves the alarm untouched.
// RULE_12: interrupt mode first trips after queue-count results above upper limit.
// RULE_13: interrupt mode alarm clears only on standby entry or any register read.
// RULE_14: after clear, interrupt trips on lower limit runs, alternating limits thereafter.
// RULE_15: fault queue bits 4:3 select 1, 2, 4 or 6 faults; default 1.
// RULE_16: standby request finishes current conversion, stores it, then stops converting.
// RULE_17: link stays usable in standby; writing zero resumes conversions.
// RULE_18: bits 6:5 pick 9 to 12 bit resolution; default 9 bit.
// RULE_19: limit registers stay readable and writable as plain storage.
// RULE_20: resolution codes map to 150, 300, 600 and 1200 ms conversions.
// RULE_21: configuration bit 1 selects comparator (0) or interrupt (1) mode.
// RULE_22: bit 0 standby, bit 2 polarity, 4:3 queue, 6:5 resolution, 7 zero.
// RULE_23: lower limit resets to 4800 hex, upper limit to 5000 hex.
// RULE_24: a non-qualifying result resets the consecutive fault count to zero.
// RULE_25: comparisons are signed on truncated values; equality is neither fault.
`timescale 1ns/100ps

module tat_thermostat #(
    parameter int unsigned P_CONV_CYC_9 = tat_pkg::CONV_CYC_9
) (
    input  wire logic        i_clk,
    input  wire logic        i_reset_n,
    input  wire logic [11:0] i_adc_sample,
    input  wire logic        i_link_clk,
    input  wire logic [1:0]  i_link_ptr,
    input  wire logic        i_link_wr,
    input  wire logic [15:0] i_link_wdata,
    input  wire logic        i_link_rd,
    output logic      [15:0] o_link_rdata,
    output logic             o_alarm_out_o,
    output logic             o_alarm_out_oe,
    output logic             o_conv_busy
);

    ////////////////////////////////////////////////////////////////////////////
    // link domain: reset sync, register copies, write decode

    logic [1:0]  link_rst_sync;
    logic        link_rst_n;
    logic [7:0]  link_cfg;
    logic [15:0] link_upper;
    logic [15:0] link_lower;
    logic [15:0] link_temp;
    logic        link_cfg_tog;
    logic        link_rd_tog;
    logic        link_rd_q;
    logic        link_temp_ack;
    logic [tat_pkg::SYNC_W-1:0] link_temp_sync;
    // result word and its toggle, written on the core clock further down
    logic [15:0] core_temp;
    logic        core_temp_tog;

    wire         wr_cfg     = i_link_wr && (i_link_ptr == tat_pkg::PTR_CFG);
    wire         wr_lower   = i_link_wr && (i_link_ptr == tat_pkg::PTR_LOWER);
    wire         wr_upper   = i_link_wr && (i_link_ptr == tat_pkg::PTR_UPPER);
    wire         wr_any     = wr_cfg || wr_lower || wr_upper;
    wire         rd_start   = i_link_rd && !link_rd_q;
    wire         temp_pend  = link_temp_sync[1] ^ link_temp_ack;
    wire         temp_take  = temp_pend && !i_link_rd;
    wire  [15:0] next_rdata;

    // register select for the read path
    assign next_rdata = (i_link_ptr == tat_pkg::PTR_TEMP)  ? link_temp :
                        (i_link_ptr == tat_pkg::PTR_CFG)   ? {8'h00, link_cfg} :
                        (i_link_ptr == tat_pkg::PTR_LOWER) ? link_lower :
                                                             link_upper; // see RULE_19

    always_ff @(posedge i_link_clk) begin
        link_rst_sync <= {link_rst_sync[0], i_reset_n};
    end
    assign link_rst_n = link_rst_sync[1];

    always_ff @(posedge i_link_clk) begin
        if (!link_rst_n) begin
            link_cfg   <= tat_pkg::CFG_RESET;     // see RULE_18
            link_lower <= tat_pkg::LOWER_RESET;   // see RULE_23
            link_upper <= tat_pkg::UPPER_RESET;   // see RULE_23
        end else begin
            if (wr_cfg) begin
                link_cfg <= i_link_wdata[7:0] & tat_pkg::CFG_WR_MASK; // see RULE_22
            end
            if (wr_lower) begin
                link_lower <= i_link_wdata & tat_pkg::LIMIT_WR_MASK;  // see RULE_19
            end
            if (wr_upper) begin
                link_upper <= i_link_wdata & tat_pkg::LIMIT_WR_MASK;  // see RULE_19
            end
        end
    end

    always_ff @(posedge i_link_clk) begin
        if (!link_rst_n) begin
            link_cfg_tog <= 1'b0;
            link_rd_tog  <= 1'b0;
            link_rd_q    <= 1'b0;
        end else begin
            link_rd_q <= i_link_rd;
            if (wr_any) begin
                link_cfg_tog <= !link_cfg_tog;
            end
            if (rd_start) begin
                link_rd_tog <= !link_rd_tog; // see RULE_13
            end
        end
    end

    // new results reach the readable copy only outside a read
    always_ff @(posedge i_link_clk) begin
        if (!link_rst_n) begin
            link_temp_sync <= '0;
            link_temp_ack  <= 1'b0;
            link_temp      <= tat_pkg::TEMP_RESET;
        end else begin
            link_temp_sync <= {link_temp_sync[tat_pkg::SYNC_W-2:0], core_temp_tog};
            if (temp_take) begin
                link_temp_ack <= link_temp_sync[1];
                link_temp     <= core_temp;  // see RULE_02
            end
        end
    end

    always_ff @(posedge i_link_clk) begin
        if (!link_rst_n) begin
            o_link_rdata <= tat_pkg::TEMP_RESET;
        end else begin
            o_link_rdata <= next_rdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // core domain: settings snapshot and read events

    logic [tat_pkg::SYNC_W-1:0] cfg_sync;
    logic [tat_pkg::SYNC_W-1:0] rd_sync;
    logic [7:0]  core_cfg;
    logic [15:0] core_upper;
    logic [15:0] core_lower;
    logic        core_sd_q;

    wire         cfg_evt  = cfg_sync[2] ^ cfg_sync[1];
    wire         rd_evt   = rd_sync[2] ^ rd_sync[1];
    wire  [1:0]  res      = core_cfg[tat_pkg::CFG_RES_HI:tat_pkg::CFG_RES_LO];
    wire  [1:0]  fq       = core_cfg[tat_pkg::CFG_FQ_HI:tat_pkg::CFG_FQ_LO];
    wire         int_mode = core_cfg[tat_pkg::CFG_MODE]; // see RULE_21
    wire         standby  = core_cfg[tat_pkg::CFG_STANDBY];
    wire         sd_rise  = standby && !core_sd_q;

    // link copies only change on a write, so they are steady when the toggle lands
    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            cfg_sync   <= '0;
            rd_sync    <= '0;
            core_cfg   <= tat_pkg::CFG_RESET;
            core_lower <= tat_pkg::LOWER_RESET;
            core_upper <= tat_pkg::UPPER_RESET;
            core_sd_q  <= 1'b0;
        end else begin
            cfg_sync  <= {cfg_sync[tat_pkg::SYNC_W-2:0], link_cfg_tog};
            rd_sync   <= {rd_sync[tat_pkg::SYNC_W-2:0], link_rd_tog};
            core_sd_q <= standby;
            if (cfg_evt) begin
                core_cfg   <= link_cfg;
                core_lower <= link_lower;
                core_upper <= link_upper;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // conversion timing and result capture

    tat_pkg::tat_conv_e conv_state;
    tat_pkg::tat_conv_e next_conv_state;
    logic [31:0] conv_cnt;

    wire  [31:0] conv_target = 32'(P_CONV_CYC_9) << res; // see RULE_20
    wire         conv_done   = (conv_state == tat_pkg::TAT_CONVERT) &&
                               (conv_cnt >= conv_target - 32'h1);
    wire  [15:0] res_mask    = (res == tat_pkg::RES_9)  ? tat_pkg::MASK_9  :
                               (res == tat_pkg::RES_10) ? tat_pkg::MASK_10 :
                               (res == tat_pkg::RES_11) ? tat_pkg::MASK_11 :
                                                          tat_pkg::MASK_12; // see RULE_18
    // see RULE_01, RULE_03, RULE_04
    wire  [15:0] next_temp   = {i_adc_sample, tat_pkg::LOW_ZERO} & res_mask;

    always_comb begin
        next_conv_state = conv_state;
        case (conv_state)
            tat_pkg::TAT_CONVERT: begin
                if (conv_done && standby) begin
                    next_conv_state = tat_pkg::TAT_STANDBY; // see RULE_16
                end
            end
            tat_pkg::TAT_STANDBY: begin
                if (!standby) begin
                    next_conv_state = tat_pkg::TAT_CONVERT; // see RULE_17
                end
            end
            default: next_conv_state = tat_pkg::TAT_CONVERT;
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            conv_state <= tat_pkg::TAT_CONVERT; // see RULE_08
            conv_cnt   <= '0;
        end else begin
            conv_state <= next_conv_state;
            if (conv_done || conv_state != tat_pkg::TAT_CONVERT) begin
                conv_cnt <= '0;
            end else begin
                conv_cnt <= conv_cnt + 32'h1;
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            core_temp     <= tat_pkg::TEMP_RESET;
            core_temp_tog <= 1'b0;
        end else if (conv_done) begin
            core_temp     <= next_temp; // see RULE_01
            core_temp_tog <= !core_temp_tog;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // limit comparison, fault queue and alarm

    logic        alarm_active;
    logic        int_phase;
    logic [2:0]  fault_cnt;

    // see RULE_06, RULE_25
    wire signed [15:0] cmp_temp  = next_temp;
    wire signed [15:0] cmp_upper = core_upper & res_mask;
    wire signed [15:0] cmp_lower = core_lower & res_mask;
    wire         above     = cmp_temp > cmp_upper;
    wire         below     = cmp_temp < cmp_lower;
    wire  [2:0]  need      = (fq == tat_pkg::FQ_1) ? tat_pkg::FQ_CNT_1 :
                             (fq == tat_pkg::FQ_2) ? tat_pkg::FQ_CNT_2 :
                             (fq == tat_pkg::FQ_4) ? tat_pkg::FQ_CNT_4 :
                                                     tat_pkg::FQ_CNT_6; // see RULE_15
    // interrupt mode alternates the limit it watches
    wire         qualify   = (int_mode && int_phase) ? below : above; // see RULE_14
    wire  [2:0]  run_next  = fault_cnt + 3'h1;
    // see RULE_05, RULE_09, RULE_12
    wire         trip      = conv_done && !alarm_active && qualify && (run_next >= need);
    wire         release_c = conv_done && alarm_active && !int_mode && below; // see RULE_10
    // standby entry clears only in interrupt mode
    wire         clear_i   = int_mode && (rd_evt || sd_rise); // see RULE_11, RULE_13

    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            alarm_active <= 1'b0;
        end else if (trip) begin
            alarm_active <= 1'b1;
        end else if (release_c || clear_i) begin
            alarm_active <= 1'b0;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            fault_cnt <= '0;
        end else if (conv_done) begin
            if (alarm_active || trip || !qualify) begin
                fault_cnt <= '0; // see RULE_24
            end else begin
                fault_cnt <= run_next;
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            int_phase <= 1'b0;
        end else if (!int_mode) begin
            int_phase <= 1'b0;
        end else if (trip) begin
            int_phase <= !int_phase; // see RULE_14
        end
    end

    // open drain: pulled low while enabled
    assign o_alarm_out_o  = 1'b0;
    assign o_alarm_out_oe = alarm_active ^ core_cfg[tat_pkg::CFG_POL]; // see RULE_07
    assign o_conv_busy    = (conv_state == tat_pkg::TAT_CONVERT);

endmodule

// ---- dv/tat_link_master.sv ----
// model of the serial master that reads and writes the block's registers
// assumes the link clock runs and that calls come from one process at a time
`timescale 1ns/100ps
module tat_link_master (
    input  wire logic        i_link_clk,
    input  wire logic [15:0] i_rdata,
    output logic      [1:0]  o_ptr,
    output logic             o_wr,
    output logic      [15:0] o_wdata,
    output logic             o_rd
);
    initial begin
        o_ptr   = 2'h1;
        o_wr    = 1'b0;
        o_wdata = 16'h0000;
        o_rd    = 1'b0;
    end
    ////////////////////////////////////////////////////////////////////////////////
    // one-cycle write pulse; the data line does not keep its value afterwards
    task automatic wr(input logic [1:0] ptr, input logic [15:0] data);
        @(posedge i_link_clk);
        #1;
        o_ptr   = ptr;
        o_wdata = data;
        o_wr    = 1'b1;
        @(posedge i_link_clk);
        #1;
        o_wr    = 1'b0;
        o_wdata = ~data;
    endtask
    // read held for two edges, data taken at the second
    task automatic rd(input logic [1:0] ptr, output logic [15:0] data);
        @(posedge i_link_clk);
        #1;
        o_ptr = ptr;
        o_rd  = 1'b1;
        repeat (2) @(posedge i_link_clk);
        data = i_rdata;
        #1;
        o_rd  = 1'b0;
    endtask
endmodule

// ---- dv/tat_thermostat_asserts.sv ----
// port checker of the thermostat block
// assumes it is bound to tat_thermostat and sees only its ports
`timescale 1ns/100ps
module tat_thermostat_asserts (
    input  wire logic        i_clk,
    input  wire logic        i_reset_n,
    input  wire logic        i_link_clk,
    input  wire logic [1:0]  i_link_ptr,
    input  wire logic        i_link_wr,
    input  wire logic [15:0] i_link_wdata,
    input  wire logic        i_link_rd,
    input  wire logic [15:0] o_link_rdata,
    input  wire logic        o_alarm_out_o,
    input  wire logic        o_alarm_out_oe,
    input  wire logic        o_conv_busy
);
    logic [3:0] quiet;
    // core cycles since the link last wrote or read
    always_ff @(posedge i_clk) begin
        if (!i_reset_n || i_link_wr || i_link_rd) begin
            quiet <= 4'h0;
        end else if (quiet != 4'hF) begin
            quiet <= quiet + 4'h1;
        end
    end
    sequence s_cfg_wr;
        i_link_wr && i_link_ptr == tat_pkg::PTR_CFG ##1 !i_link_wr && i_link_ptr == tat_pkg::PTR_CFG;
    endsequence
    sequence s_lim_wr;
        i_link_wr && i_link_ptr[1] ##1 !i_link_wr && $stable(i_link_ptr);
    endsequence
    ////////////////////////////////////////////////////////////////////////////////
    alarm_pin_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        o_alarm_out_o == 1'b0) else $error("alarm pin data not low");
    reset_out_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        $rose(i_reset_n) |-> !o_alarm_out_oe && o_conv_busy) else $error("bad outputs at reset");
    alarm_cause_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        $changed(o_alarm_out_oe) |-> o_conv_busy || $past(o_conv_busy) || quiet < 4'h8)
        else $error("alarm changed without conversion or access");
    busy_hold_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        $fell(o_conv_busy) |=> !o_conv_busy [*4]) else $error("standby left at once");
    busy_resume_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        $rose(o_conv_busy) |-> quiet < 4'h8) else $error("conversion resumed without a write");
    low_nibble_a: assert property (@(posedge i_link_clk) disable iff (!i_reset_n)
        $past(i_link_ptr) != tat_pkg::PTR_CFG |-> o_link_rdata[3:0] == tat_pkg::LOW_ZERO)
        else $error("low nibble of word not zero");
    cfg_readback_a: assert property (@(posedge i_link_clk) disable iff (!i_reset_n)
        s_cfg_wr |=> o_link_rdata == {9'h000, $past(i_link_wdata[6:0], 2)})
        else $error("configuration read back differs");
    limit_readback_a: assert property (@(posedge i_link_clk) disable iff (!i_reset_n)
        s_lim_wr |=> o_link_rdata == ($past(i_link_wdata, 2) & 16'hFFF0))
        else $error("limit read back differs");
endmodule
bind tat_thermostat tat_thermostat_asserts u_asserts (
    .i_clk(i_clk), .i_reset_n(i_reset_n), .i_link_clk(i_link_clk), .i_link_ptr(i_link_ptr),
    .i_link_wr(i_link_wr), .i_link_wdata(i_link_wdata), .i_link_rd(i_link_rd),
    .o_link_rdata(o_link_rdata), .o_alarm_out_o(o_alarm_out_o),
    .o_alarm_out_oe(o_alarm_out_oe), .o_conv_busy(o_conv_busy));

// ---- dv/thermal_alarm_thermostat_tb_top.sv ----
// self-checking bench of the thermostat block with a link master model
// assumes the design package is compiled first; 9-bit conversions are shortened to 40 cycles
`timescale 1ns/100ps
module thermal_alarm_thermostat_tb_top;
    localparam int CONV = 40;
    typedef struct {
        logic [1:0]  res;
        logic [11:0] smp;
        logic [15:0] exp;
    } tat_row_s;
    logic        clk      = 1'b0;
    logic        lclk     = 1'b0;
    logic        rst_n    = 1'b0;
    logic [11:0] sample   = 12'h000;
    logic [1:0]  ptr;
    logic        wr;
    logic        rd;
    logic [15:0] wdata;
    logic [15:0] rdata;
    logic [15:0] got;
    logic        pin_o;
    logic        oe;
    logic        busy;
    int          failures = 0;
    int          n_checks = 0;
    int          cyc      = 0;
    int          need [4] = '{1, 2, 4, 6};
    tat_row_s    rows [6] = '{'{2'h3, 12'hE6F, 16'hE6F0}, '{2'h2, 12'hE6F, 16'hE6E0},
        '{2'h1, 12'hE6F, 16'hE6C0}, '{2'h0, 12'hE6F, 16'hE680}, '{2'h0, 12'h7D0, 16'h7D00},
        '{2'h2, 12'h0A2, 16'h0A20}};
    always #4 clk = ~clk;
    always #24 lclk = ~lclk;
    tat_thermostat #(.P_CONV_CYC_9(CONV)) uut (
        .i_clk(clk), .i_reset_n(rst_n), .i_adc_sample(sample), .i_link_clk(lclk),
        .i_link_ptr(ptr), .i_link_wr(wr), .i_link_wdata(wdata), .i_link_rd(rd),
        .o_link_rdata(rdata), .o_alarm_out_o(pin_o), .o_alarm_out_oe(oe), .o_conv_busy(busy));
    tat_link_master link (
        .i_link_clk(lclk), .i_rdata(rdata), .o_ptr(ptr), .o_wr(wr), .o_wdata(wdata), .o_rd(rd));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic results();
        if (failures == 0 && n_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic check(input logic [15:0] act, input logic [15:0] exp, input string what);
        n_checks++;
        if (act !== exp) begin
            failures++;
            $display("ERROR %0t %s got %h want %h", $time, what, act, exp);
        end
    endtask
    task automatic chk_oe(input logic exp);
        check({15'h0000, oe}, {15'h0000, exp}, "alarm enable");
    endtask
    task automatic put(input logic [11:0] smp);
        @(posedge clk);
        #1;
        sample = smp;
    endtask
    task automatic wc(input int n);
        repeat (n * CONV) @(posedge clk);
        #1;
    endtask
    // standby then restart, so conversions end one period less 16 cycles after return (24 at 9 bits), then every period
    task automatic sync(input logic [7:0] cfg);
        int k;
        k = 0;
        link.wr(tat_pkg::PTR_CFG, {8'h00, cfg | 8'h01});
        while (busy !== 1'b0 && k < 1000) begin
            @(posedge clk);
            k++;
        end
        check({15'h0000, busy}, 16'h0000, "standby");
        link.wr(tat_pkg::PTR_CFG, {8'h00, cfg});
        repeat (20) @(posedge clk);
        #1;
    endtask
    task automatic arm(input logic [7:0] cfg);
        put(12'h470);
        sync(cfg);
        wc(1);
        put(12'h510);
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc == 40000) begin
            failures++;
            results();
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (4) @(posedge lclk);
        @(posedge clk);
        #1;
        rst_n = 1'b1;
        repeat (3) @(posedge lclk);
        chk_oe(1'b0);
        link.rd(tat_pkg::PTR_CFG, got);
        check(got, 16'h0000, "cfg reset");
        link.rd(tat_pkg::PTR_LOWER, got);
        check(got, 16'h4800, "lower reset");
        link.rd(tat_pkg::PTR_UPPER, got);
        check(got, 16'h5000, "upper reset");
        link.wr(tat_pkg::PTR_LOWER, 16'h123F);
        link.rd(tat_pkg::PTR_LOWER, got);
        check(got, 16'h1230, "limit store");
        link.wr(tat_pkg::PTR_LOWER, 16'h4800);
        for (int i = 0; i < 6; i++) begin
            put(rows[i].smp);
            sync({1'b0, rows[i].res, 5'h00});
            repeat ((CONV << rows[i].res) + 40) @(posedge clk);
            link.rd(tat_pkg::PTR_TEMP, got);
            check(got, rows[i].exp, "temp");
        end
        for (int f = 0; f < 4; f++) begin
            arm({3'h0, 2'(f), 3'h0});
            wc(need[f] - 1);
            chk_oe(1'b0);
            wc(1);
            chk_oe(1'b1);
        end
        arm(8'h08);
        wc(1);
        put(12'h490);
        wc(1);
        put(12'h510);
        wc(1);
        chk_oe(1'b0);
        wc(1);
        chk_oe(1'b1);
        link.wr(tat_pkg::PTR_LOWER, 16'h4850);
        put(12'h480);
        wc(2);
        chk_oe(1'b1);
        link.wr(tat_pkg::PTR_CFG, 16'h0009);
        repeat (60) @(posedge clk);
        chk_oe(1'b1);
        link.rd(tat_pkg::PTR_LOWER, got);
        check(got, 16'h4850, "standby read");
        link.wr(tat_pkg::PTR_CFG, 16'h0008);
        put(12'h470);
        wc(2);
        chk_oe(1'b0);
        link.wr(tat_pkg::PTR_CFG, 16'h0004);
        put(12'h500);
        wc(2);
        chk_oe(1'b1);
        put(12'h470);
        sync(8'h00);
        wc(1);
        link.wr(tat_pkg::PTR_CFG, 16'h0002);
        put(12'h510);
        wc(2);
        chk_oe(1'b1);
        wc(1);
        chk_oe(1'b1);
        link.rd(tat_pkg::PTR_UPPER, got);
        repeat (8) @(posedge clk);
        chk_oe(1'b0);
        wc(1);
        chk_oe(1'b0);
        put(12'h460);
        wc(2);
        chk_oe(1'b1);
        link.rd(tat_pkg::PTR_TEMP, got);
        check(got, 16'h4600, "temp");
        repeat (8) @(posedge clk);
        chk_oe(1'b0);
        wc(1);
        chk_oe(1'b0);
        put(12'h510);
        wc(2);
        chk_oe(1'b1);
        link.wr(tat_pkg::PTR_CFG, 16'h0003);
        repeat (8) @(posedge clk);
        chk_oe(1'b0);
        results();
    end
endmodule
